// >>> logic/cfd_pkg.sv
// How it works
// - window codes 11/10=25%, 01=50%, 00=75%
// - i2c one primary pins when bit set
// - i2c two primary pins when bit set
// - scan port follows enable bit
// - debug pair 1/2/3 for 11/10/01
// - dac outputs joined when bit zero
// - regset one level is code plus one, code 7 gives zero
// - regset two level is code plus one, code 7 gives zero
// - boot mode single/dual/protected/privileged
// - alternate vectors need boot segment
// - trim words read-only, writes ignored
// - trim words at fixed addresses, low bits
// - two read-only 24-bit identity words
// - 64 otp words 0x800f80 to 0x800ffe
// - otp written once per reset, in programming mode only
package cfd_pkg;
  // configuration space word addresses
  localparam logic [23:0] AMP1_TRIM_ADDR = 24'h800e48;
  localparam logic [23:0] AMP2_TRIM_ADDR = 24'h800e4c;
  localparam logic [23:0] ISRC_TRIM_ADDR = 24'h800e78;
  // identity word addresses near top of space
  localparam logic [23:0] PART_ID_ADDR = 24'hff0000;
  localparam logic [23:0] SIL_REV_ADDR = 24'hff0002;
  // otp area bounds
  localparam logic [23:0] OTP_BASE_ADDR = 24'h800f80;
  localparam logic [23:0] OTP_LAST_ADDR = 24'h800ffe;
  localparam int OTP_WORDS = 64;
  // trim field width in low bits
  localparam int TRIM_BITS = 6;
  // configuration word field positions
  localparam int WIN_POS = 0;
  localparam int I2C1_POS = 2;
  localparam int I2C2_POS = 3;
  localparam int SCAN_POS = 4;
  localparam int DBG_POS = 5;
  localparam int DAC_POS = 7;
  localparam int CTX1_POS = 8;
  localparam int CTX2_POS = 11;
  localparam int BOOT_POS = 14;
  localparam int AIVT_POS = 16;
  localparam int BSEG_POS = 17;
  // settings after reset before the latch
  localparam logic [23:0] CFG_RESET = 24'h000000;
  localparam logic [23:0] WORD_RESET = 24'h000000;
  // window percent codes
  localparam logic [6:0] WIN_PCT_25 = 7'h19;
  localparam logic [6:0] WIN_PCT_50 = 7'h32;
  localparam logic [6:0] WIN_PCT_75 = 7'h4b;
  // boot organisation
  typedef enum logic [1:0] {
    BOOT_PRIVILEGED,
    BOOT_PROTECTED,
    BOOT_DUAL,
    BOOT_SINGLE
  } cfd_boot_e;
endpackage

// >>> logic/cfd_level_map.sv
`timescale 1ns/100ps
// maps a three bit register set code to a priority level
module cfd_level_map (
  input wire logic [2:0] code,
  output logic [3:0] level,
  output logic valid
);
  // reserved code gives level zero and not valid
  always_comb begin
    valid = (code != 3'h7);
    level = valid ? ({1'b0, code} + 4'h1) : 4'h0;
  end
endmodule

// >>> logic/cfd_otp_store.sv
`timescale 1ns/100ps
// one-time-programmable user words in flip-flops
module cfd_otp_store #(
  parameter int WORDS = 64
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic progMode,
  input wire logic progWrite,
  input wire logic [$clog2(WORDS)-1:0] progIndex,
  input wire logic [23:0] progData,
  input wire logic [$clog2(WORDS)-1:0] readIndex,
  output logic [23:0] readData
);
  logic [23:0] mem_q [WORDS];
  logic [WORDS-1:0] burnt_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      burnt_q <= '0;
      for (int i = 0; i < WORDS; i++) begin
        mem_q[i] <= 24'h000000;
      end
    end else if (progMode && progWrite && !burnt_q[progIndex]) begin
      mem_q[progIndex] <= progData;
      burnt_q[progIndex] <= 1'b1;
    end
  end
  // reads always allowed
  assign readData = mem_q[readIndex];
  AST_OTPLOCK: assert property (@(posedge clock) disable iff (rst)
    !progMode |=> $stable(burnt_q))
    else $error("otp burnt outside programming");
endmodule

// >>> logic/cfd_config_decode.sv
`timescale 1ns/100ps
// decodes latched configuration and serves table reads
module cfd_config_decode #(
  parameter logic [23:0] PART_ID = 24'h00a5a5, // arbitrary value
  parameter logic [23:0] SIL_REV = 24'h000001 // arbitrary value
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [23:0] nvConfig,
  input wire logic [23:0] nvAmp1Trim,
  input wire logic [23:0] nvAmp2Trim,
  input wire logic [23:0] nvIsrcTrim,
  input wire logic progMode,
  input wire logic progWrite,
  input wire logic [5:0] progIndex,
  input wire logic [23:0] progData,
  input wire logic tableRead,
  input wire logic tableWrite,
  input wire logic [23:0] tableAddr,
  input wire logic [23:0] tableWdata,
  output logic [23:0] tableRdata,
  output logic tableRvalid,
  output logic [6:0] watchdogWindowPct,
  output logic i2cOnePrimary,
  output logic i2cTwoPrimary,
  output logic scanPortEnable,
  output logic [2:0] debugPairOneHot,
  output logic debugReserved,
  output logic dacCrossConnect,
  output logic [3:0] altRegsetOneLevel,
  output logic [3:0] altRegsetTwoLevel,
  output cfd_pkg::cfd_boot_e bootPartitionMode,
  output logic altVectorEnable,
  output logic configValid
);
  // latched nonvolatile copies
  logic [23:0] cfg_q;
  logic [23:0] amp1_q, amp2_q, isrc_q;
  logic loaded_q;
  // decoded next values
  logic [6:0] winPct_d;
  logic [2:0] dbg_d;
  logic [3:0] lvl1, lvl2;
  logic lvl1Ok, lvl2Ok;
  logic [23:0] otpData;
  logic [23:0] rdata_d;
  logic unusedWrite;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      loaded_q <= 1'b0;
      cfg_q <= cfd_pkg::CFG_RESET;
      amp1_q <= cfd_pkg::WORD_RESET;
      amp2_q <= cfd_pkg::WORD_RESET;
      isrc_q <= cfd_pkg::WORD_RESET;
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      cfg_q <= nvConfig;
      amp1_q <= {18'h00000, nvAmp1Trim[cfd_pkg::TRIM_BITS-1:0]};
      amp2_q <= {18'h00000, nvAmp2Trim[cfd_pkg::TRIM_BITS-1:0]};
      isrc_q <= {18'h00000, nvIsrcTrim[cfd_pkg::TRIM_BITS-1:0]};
    end
  end

  always_comb begin
    case (cfg_q[cfd_pkg::WIN_POS +: 2])
      2'h3: winPct_d = cfd_pkg::WIN_PCT_25;
      2'h2: winPct_d = cfd_pkg::WIN_PCT_25;
      2'h1: winPct_d = cfd_pkg::WIN_PCT_50;
      default: winPct_d = cfd_pkg::WIN_PCT_75;
    endcase
  end

  always_comb begin
    case (cfg_q[cfd_pkg::DBG_POS +: 2])
      2'h3: dbg_d = 3'h1;
      2'h2: dbg_d = 3'h2;
      2'h1: dbg_d = 3'h4;
      default: dbg_d = 3'h0;
    endcase
  end

  cfd_level_map u_lvl1 (
    .code(cfg_q[cfd_pkg::CTX1_POS +: 3]),
    .level(lvl1),
    .valid(lvl1Ok)
  );
  cfd_level_map u_lvl2 (
    .code(cfg_q[cfd_pkg::CTX2_POS +: 3]),
    .level(lvl2),
    .valid(lvl2Ok)
  );

  // registered settings outputs, zero while reset is held
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      watchdogWindowPct <= 7'h00;
      i2cOnePrimary <= 1'b0;
      i2cTwoPrimary <= 1'b0;
      scanPortEnable <= 1'b0;
      debugPairOneHot <= 3'h0;
      debugReserved <= 1'b0;
      dacCrossConnect <= 1'b0;
      altRegsetOneLevel <= 4'h0;
      altRegsetTwoLevel <= 4'h0;
      bootPartitionMode <= cfd_pkg::BOOT_PRIVILEGED;
      altVectorEnable <= 1'b0;
      configValid <= 1'b0;
    end else begin
      watchdogWindowPct <= winPct_d;
      i2cOnePrimary <= cfg_q[cfd_pkg::I2C1_POS];
      i2cTwoPrimary <= cfg_q[cfd_pkg::I2C2_POS];
      scanPortEnable <= cfg_q[cfd_pkg::SCAN_POS];
      debugPairOneHot <= dbg_d;
      debugReserved <= loaded_q && (dbg_d == 3'h0);
      dacCrossConnect <= loaded_q && !cfg_q[cfd_pkg::DAC_POS];
      altRegsetOneLevel <= lvl1;
      altRegsetTwoLevel <= lvl2;
      bootPartitionMode <= cfd_pkg::cfd_boot_e'(cfg_q[cfd_pkg::BOOT_POS +: 2]);
      altVectorEnable <= cfg_q[cfd_pkg::AIVT_POS] && cfg_q[cfd_pkg::BSEG_POS];
      configValid <= loaded_q;
    end
  end

  cfd_otp_store #(
    .WORDS(cfd_pkg::OTP_WORDS)
  ) u_otp (
    .clock(clock),
    .rst(rst),
    .progMode(progMode),
    .progWrite(progWrite),
    .progIndex(progIndex),
    .progData(progData),
    .readIndex(tableAddr[6:1]),
    .readData(otpData)
  );

  // table read decode
  always_comb begin
    rdata_d = 24'h000000;
    if (tableAddr == cfd_pkg::AMP1_TRIM_ADDR) begin
      rdata_d = amp1_q;
    end else if (tableAddr == cfd_pkg::AMP2_TRIM_ADDR) begin
      rdata_d = amp2_q;
    end else if (tableAddr == cfd_pkg::ISRC_TRIM_ADDR) begin
      rdata_d = isrc_q;
    end else if (tableAddr == cfd_pkg::PART_ID_ADDR) begin
      rdata_d = PART_ID;
    end else if (tableAddr == cfd_pkg::SIL_REV_ADDR) begin
      rdata_d = SIL_REV;
    end else if (tableAddr >= cfd_pkg::OTP_BASE_ADDR &&
                 tableAddr <= cfd_pkg::OTP_LAST_ADDR) begin
      rdata_d = otpData;
    end
  end

  assign unusedWrite = tableWrite ^ (|tableWdata);

  // read answer one cycle after request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tableRdata <= 24'h000000;
      tableRvalid <= 1'b0;
    end else begin
      tableRvalid <= tableRead;
      tableRdata <= tableRead ? rdata_d : 24'h000000;
    end
  end

  // software copies trims after configValid
  // outputs trail the latch by one edge, so only check once valid
  AST_WIN: assert property (@(posedge clock) disable iff (rst)
    configValid |-> watchdogWindowPct == winPct_d)
    else $error("window percent wrong");
  // both upper codes give the quarter window
  AST_WIN25: assert property (@(posedge clock) disable iff (rst)
    configValid && cfg_q[cfd_pkg::WIN_POS + 1]
      |-> watchdogWindowPct == cfd_pkg::WIN_PCT_25)
    else $error("window not a quarter");
  AST_WIN50: assert property (@(posedge clock) disable iff (rst)
    configValid && cfg_q[cfd_pkg::WIN_POS +: 2] == 2'h1
      |-> watchdogWindowPct == cfd_pkg::WIN_PCT_50)
    else $error("window not a half");
  AST_WIN75: assert property (@(posedge clock) disable iff (rst)
    configValid && cfg_q[cfd_pkg::WIN_POS +: 2] == 2'h0
      |-> watchdogWindowPct == cfd_pkg::WIN_PCT_75)
    else $error("window not three quarters");
  AST_I2C1: assert property (@(posedge clock) disable iff (rst)
    ##1 i2cOnePrimary == $past(cfg_q[cfd_pkg::I2C1_POS]))
    else $error("i2c one routing wrong");
  AST_I2C2: assert property (@(posedge clock) disable iff (rst)
    ##1 i2cTwoPrimary == $past(cfg_q[cfd_pkg::I2C2_POS]))
    else $error("i2c two routing wrong");
  AST_SCAN: assert property (@(posedge clock) disable iff (rst)
    configValid |-> scanPortEnable == cfg_q[cfd_pkg::SCAN_POS])
    else $error("scan enable wrong");
  AST_DBG: assert property (@(posedge clock) disable iff (rst)
    configValid |-> $countones(debugPairOneHot) == (debugReserved ? 0 : 1))
    else $error("debug pair wrong");
  AST_DBG1: assert property (@(posedge clock) disable iff (rst)
    configValid && cfg_q[cfd_pkg::DBG_POS +: 2] == 2'h3
      |-> debugPairOneHot == 3'h1)
    else $error("debug pair one not chosen");
  AST_DBG2: assert property (@(posedge clock) disable iff (rst)
    configValid && cfg_q[cfd_pkg::DBG_POS +: 2] == 2'h2
      |-> debugPairOneHot == 3'h2)
    else $error("debug pair two not chosen");
  AST_DBG3: assert property (@(posedge clock) disable iff (rst)
    configValid && cfg_q[cfd_pkg::DBG_POS +: 2] == 2'h1
      |-> debugPairOneHot == 3'h4)
    else $error("debug pair three not chosen");
  AST_DBGRES: assert property (@(posedge clock) disable iff (rst)
    configValid |-> debugReserved == (cfg_q[cfd_pkg::DBG_POS +: 2] == 2'h0))
    else $error("reserved debug flag wrong");
  AST_DAC: assert property (@(posedge clock) disable iff (rst)
    configValid |-> dacCrossConnect == !cfg_q[cfd_pkg::DAC_POS])
    else $error("dac cross connect wrong");
  AST_LVL: assert property (@(posedge clock) disable iff (rst)
    configValid && lvl1Ok |-> altRegsetOneLevel ==
      {1'b0, cfg_q[cfd_pkg::CTX1_POS +: 3]} + 4'h1)
    else $error("regset one level wrong");
  AST_LVL2: assert property (@(posedge clock) disable iff (rst)
    configValid && lvl2Ok |-> altRegsetTwoLevel ==
      {1'b0, cfg_q[cfd_pkg::CTX2_POS +: 3]} + 4'h1)
    else $error("regset two level wrong");
  AST_LVLRES1: assert property (@(posedge clock) disable iff (rst)
    configValid && cfg_q[cfd_pkg::CTX1_POS +: 3] == 3'h7
      |-> altRegsetOneLevel == 4'h0)
    else $error("regset one reserved level wrong");
  AST_LVLRES2: assert property (@(posedge clock) disable iff (rst)
    configValid && cfg_q[cfd_pkg::CTX2_POS +: 3] == 3'h7
      |-> altRegsetTwoLevel == 4'h0)
    else $error("regset two reserved level wrong");
  AST_BOOT: assert property (@(posedge clock) disable iff (rst)
    configValid && cfg_q[cfd_pkg::BOOT_POS +: 2] == 2'h3
      |-> bootPartitionMode == cfd_pkg::BOOT_SINGLE)
    else $error("boot mode not single");
  AST_BOOTPRIV: assert property (@(posedge clock) disable iff (rst)
    configValid && cfg_q[cfd_pkg::BOOT_POS +: 2] == 2'h0
      |-> bootPartitionMode == cfd_pkg::BOOT_PRIVILEGED)
    else $error("boot mode not privileged");
  AST_AIVT: assert property (@(posedge clock) disable iff (rst)
    altVectorEnable |-> cfg_q[cfd_pkg::BSEG_POS])
    else $error("vectors without boot segment");
  AST_HOLD: assert property (@(posedge clock) disable iff (rst)
    configValid |=> $stable(cfg_q) && $stable(amp1_q))
    else $error("configuration changed after load");
  AST_TRIM: assert property (@(posedge clock) disable iff (rst)
    tableRead && tableAddr == cfd_pkg::AMP1_TRIM_ADDR
      |=> tableRvalid && tableRdata[23:cfd_pkg::TRIM_BITS] == '0)
    else $error("trim upper bits set");
  // second amplifier trim upper bits clear
  AST_TRIM2: assert property (@(posedge clock) disable iff (rst)
    tableRead && tableAddr == cfd_pkg::AMP2_TRIM_ADDR
      |=> tableRdata[23:cfd_pkg::TRIM_BITS] == '0)
    else $error("second trim upper bits set");
  // current source trim upper bits clear
  AST_TRIMI: assert property (@(posedge clock) disable iff (rst)
    tableRead && tableAddr == cfd_pkg::ISRC_TRIM_ADDR
      |=> tableRdata[23:cfd_pkg::TRIM_BITS] == '0)
    else $error("source trim upper bits set");
  // a write never moves a loaded trim
  AST_WRITE: assert property (@(posedge clock) disable iff (rst)
    tableWrite && loaded_q
      |=> $stable(amp1_q) && $stable(amp2_q) && $stable(isrc_q))
    else $error("trim changed by write");
  AST_ID: assert property (@(posedge clock) disable iff (rst)
    tableRead && tableAddr == cfd_pkg::PART_ID_ADDR
      |=> tableRdata == PART_ID)
    else $error("part identifier wrong");
  AST_REV: assert property (@(posedge clock) disable iff (rst)
    tableRead && tableAddr == cfd_pkg::SIL_REV_ADDR
      |=> tableRdata == SIL_REV)
    else $error("silicon revision wrong");
  // reads inside the user area return the stored word
  AST_OTPRD: assert property (@(posedge clock) disable iff (rst)
    tableRead && tableAddr >= cfd_pkg::OTP_BASE_ADDR &&
      tableAddr <= cfd_pkg::OTP_LAST_ADDR
      |=> tableRvalid && tableRdata == $past(otpData))
    else $error("otp read wrong");
endmodule

// >>> bench/cfd_config_decode_tb.sv
`timescale 1ns/100ps
// self-checking bench for the configuration decoder
module cfd_config_decode_tb;
  localparam logic [23:0] ID_V = 24'h00c3e1; // arbitrary value
  localparam logic [23:0] REV_V = 24'h000042; // arbitrary value
  logic clock = 1'b0; // 25 MHz system clock
  logic rst = 1'b1; // async reset, high
  logic [23:0] nvConfig = '0, nvAmp1Trim = '0, nvAmp2Trim = '0;
  logic [23:0] nvIsrcTrim = '0, progData = '0, tableAddr = '0;
  logic [23:0] tableWdata = '0, tableRdata, t1, t2, t3, cfg;
  logic progMode = 1'b0, progWrite = 1'b0, tableRead = 1'b0;
  logic tableWrite = 1'b0, tableRvalid, i2c1, i2c2, scan, dres, dac;
  logic avec, cvalid;
  logic [5:0] progIndex = '0;
  logic [6:0] wpct;
  logic [2:0] dbg;
  logic [3:0] lv1, lv2;
  cfd_pkg::cfd_boot_e boot;
  logic [31:0] seed = 32'h54a135fc; // fixed seed keeps runs repeatable
  logic [23:0] ov [64]; // first value programmed into each otp word
  int err_count = 0;
  int n_compared = 0;

  cfd_config_decode #(.PART_ID(ID_V), .SIL_REV(REV_V)) dut (
    .clock(clock), .rst(rst), .nvConfig(nvConfig),
    .nvAmp1Trim(nvAmp1Trim), .nvAmp2Trim(nvAmp2Trim),
    .nvIsrcTrim(nvIsrcTrim), .progMode(progMode), .progWrite(progWrite),
    .progIndex(progIndex), .progData(progData), .tableRead(tableRead),
    .tableWrite(tableWrite), .tableAddr(tableAddr),
    .tableWdata(tableWdata), .tableRdata(tableRdata),
    .tableRvalid(tableRvalid), .watchdogWindowPct(wpct),
    .i2cOnePrimary(i2c1), .i2cTwoPrimary(i2c2), .scanPortEnable(scan),
    .debugPairOneHot(dbg), .debugReserved(dres), .dacCrossConnect(dac),
    .altRegsetOneLevel(lv1), .altRegsetTwoLevel(lv2),
    .bootPartitionMode(boot), .altVectorEnable(avec),
    .configValid(cvalid));

  // free-running clock
  always #20 clock = ~clock;

  // xorshift source of random stimulus
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // level expected for a register set code, zero when reserved
  function automatic logic [23:0] lvl(input logic [2:0] c);
    return (c == 3'h7) ? 24'h0 : 24'(c) + 24'h1;
  endfunction

  // one comparison, counted
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // reset with a new configuration and new trims on the nv inputs
  task automatic reboot(input logic [23:0] c);
    @(posedge clock);
    t1 = 24'(xs());
    t2 = 24'(xs());
    t3 = 24'(xs());
    rst <= 1'b1;
    nvConfig <= c;
    nvAmp1Trim <= t1;
    nvAmp2Trim <= t2;
    nvIsrcTrim <= t3;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask

  // all decoded settings against the configuration word
  task automatic chkcfg(input logic [23:0] c);
    chk(24'(wpct), c[1] ? 24'h19 : (c[0] ? 24'h32 : 24'h4b));
    chk(24'(i2c1), 24'(c[2]));
    chk(24'(i2c2), 24'(c[3]));
    chk(24'(scan), 24'(c[4]));
    chk(24'(dbg), (c[6:5] == 2'h0) ? 24'h0 : 24'h1 << (2'h3 - c[6:5]));
    chk(24'(dres), 24'(c[6:5] == 2'h0));
    chk(24'(dac), 24'(!c[7]));
    chk(24'(lv1), lvl(c[10:8]));
    chk(24'(lv2), lvl(c[13:11]));
    chk(24'(boot), 24'(c[15:14]));
    chk(24'(avec), 24'(c[16] & c[17]));
    chk(24'(cvalid), 24'h1);
  endtask

  // table read: request taken at one edge, answer stands the next cycle
  task automatic rd(input logic [23:0] a, input logic [23:0] e);
    @(posedge clock);
    tableRead <= 1'b1;
    tableAddr <= a;
    @(posedge clock);
    tableRead <= 1'b0;
    #1;
    chk(24'(tableRvalid), 24'h1);
    chk(tableRdata, e);
  endtask

  // run-time table write, which the block must ignore
  task automatic wr(input logic [23:0] a, input logic [23:0] d);
    @(posedge clock);
    tableWrite <= 1'b1;
    tableAddr <= a;
    tableWdata <= d;
    @(posedge clock);
    tableWrite <= 1'b0;
  endtask

  // otp programming strobe, with or without programming mode
  task automatic pg(input logic m, input int i, input logic [23:0] d);
    @(posedge clock);
    progMode <= m;
    progWrite <= 1'b1;
    progIndex <= 6'(i);
    progData <= d;
    @(posedge clock);
    progWrite <= 1'b0;
    progMode <= 1'b0;
  endtask

  // verdict and end of run
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog against a hang, far beyond the roughly 850 cycles needed
  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    report_and_stop();
  end

  // main sequence: corner words first, then random ones
  initial begin
    repeat (5) @(posedge clock);
    for (int i = 0; i < 24; i++) begin
      cfg = (i == 0) ? 24'h000000 : (i == 1) ? 24'hffffff :
            (i == 2) ? 24'h015555 : (i == 3) ? 24'h02aaaa : 24'(xs());
      reboot(cfg);
      chkcfg(cfg);
      // settings must not follow the nv input after the latch
      nvConfig <= ~cfg;
      repeat (4) @(posedge clock);
      #1;
      chkcfg(cfg);
    end
    // software reads the trims only after the settings are valid
    wr(cfd_pkg::AMP1_TRIM_ADDR, ~t1);
    rd(cfd_pkg::AMP1_TRIM_ADDR, t1 & 24'h3f);
    rd(cfd_pkg::AMP2_TRIM_ADDR, t2 & 24'h3f);
    rd(cfd_pkg::ISRC_TRIM_ADDR, t3 & 24'h3f);
    wr(cfd_pkg::PART_ID_ADDR, ~ID_V);
    rd(cfd_pkg::PART_ID_ADDR, ID_V);
    rd(cfd_pkg::SIL_REV_ADDR, REV_V);
    rd(24'h800e4a, 24'h0); // unmapped address reads zero
    // a write outside programming mode must not land
    pg(1'b0, 5, 24'h123456);
    rd(cfd_pkg::OTP_BASE_ADDR + 24'h00000a, 24'h0);
    for (int i = 0; i < 64; i++) begin
      ov[i] = 24'(xs());
      pg(1'b1, i, ov[i]);
    end
    // second programming pass and run-time writes must both be lost
    for (int i = 0; i < 64; i++) begin
      pg(1'b1, i, ~ov[i]);
      wr(cfd_pkg::OTP_BASE_ADDR + 24'(2 * i), ~ov[i]);
    end
    for (int i = 0; i < 64; i++) begin
      rd(cfd_pkg::OTP_BASE_ADDR + 24'(2 * i), ov[i]);
    end
    report_and_stop();
  end
endmodule
